// ---- pbc_regs.sv ----
// Summary of operation
// - Strap low keeps negotiation disabled
// - Writing one re-enables negotiation; reset too
// - Enable bit writes ignored while strap low
// - Enable bit reads last written, reset one
// - Negotiation on: speed and duplex bits ignored
// - Fiber mode: enable reads zero, unwritable
// - Power-down bit enters and leaves low power
// - Management interface stays alive when powered down
// - Power-down bit reads current power state
// - Restart bit restarts negotiation, self-clears
// - Restart only acts while negotiation enabled
// - Restart bit always reads zero
// - Duplex resets half; forced when negotiation off
// - Negotiation on: duplex read-only, shows result
// - Fiber: duplex set by write or pin
// - Negotiation off: speed bit forces 100/10; fiber mode forces 100
`timescale 1ns/1ps
`include "pbc_consts.svh"

module pbc_regs
  import pbc_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = `PBC_PHY_ADDR,
  parameter logic [5:0] PREAMBLE_LEN = `PBC_PREAMBLE_LEN
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Management serial interface
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe_n,
  // Configuration pins
  input wire logic negotiationStrapPin,
  input wire logic fiberModePin,
  input wire logic fiberDuplexPin,
  // Negotiation engine, same clock
  input wire logic anDone,
  input wire logic anFullDuplex,
  input wire logic anSpeed100,
  // Control outputs
  output logic anEnable,
  output logic anRestart,
  output logic powerDown,
  output logic linkSpeed100,
  output logic linkFullDuplex
);

  localparam pbc_regs_s RESET_STATE = '{
    state: ST_IDLE,
    cnt: 5'h00,
    ones: 6'h00,
    shift: 16'h0000,
    isRead: 1'h0,
    regZero: 1'h0,
    mdcPrev: 1'h0,
    mdioOut: 1'h0,
    mdioOe_n: 1'h1,
    anEnableBit: `PBC_RST_AN_EN,
    speedBit: `PBC_RST_SPEED,
    powerDown: `PBC_RST_PDOWN,
    duplexBit: `PBC_RST_DUPLEX,
    anRestart: 1'h0,
    anEnable: 1'h0,
    linkSpeed100: 1'h0,
    linkFullDuplex: 1'h0,
    fxDupPrev: 1'h0
  };

  pbc_regs_s q;
  pbc_regs_s next_q;
  logic [4:0] pinSync;
  logic mdcS;
  logic mdioS;
  logic strapS;
  logic fiberS;
  logic fxDupS;
  logic mdcRise;
  logic wrCommit;
  logic [15:0] wrValue;
  logic [15:0] readValue;
  logic [1:0] opcNow;
  logic [9:0] addrNow;
  logic regZeroNow;

  if (PREAMBLE_LEN < 6'h01 || PREAMBLE_LEN > 6'h20)
  begin : g_bad_preamble
    $error("pbc_regs: PREAMBLE_LEN must lie in 1..32");
  end

  pbc_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async({mdc, mdioIn, negotiationStrapPin, fiberModePin,
            fiberDuplexPin}),
    .sync(pinSync)
  );

  assign mdcS = pinSync[4];
  assign mdioS = pinSync[3];
  assign strapS = pinSync[2];
  assign fiberS = pinSync[1];
  assign fxDupS = pinSync[0];

  // Frame decode helpers; runs regardless of power-down
  assign mdcRise = mdcS & ~q.mdcPrev;
  assign opcNow = {q.shift[0], mdioS};
  assign addrNow = {q.shift[8:0], mdioS};
  assign regZeroNow = (addrNow[4:0] == `PBC_REG_CONTROL);
  assign wrValue = {q.shift[14:0], mdioS};
  assign wrCommit = mdcRise && (q.state == ST_WDATA) &&
                    (q.cnt == `PBC_DATA_LAST) && q.regZero;

  // Read image; restart and reserved bits read zero
  always_comb
  begin
    readValue = 16'h0000;
    readValue[`PBC_BIT_SPEED] = fiberS | q.speedBit;
    readValue[`PBC_BIT_AN_EN] = ~fiberS & q.anEnableBit;
    readValue[`PBC_BIT_PDOWN] = q.powerDown;
    readValue[`PBC_BIT_DUPLEX] = q.duplexBit;
  end

  always_comb
  begin
    next_q = q;
    next_q.mdcPrev = mdcS;
    next_q.anRestart = 1'h0;
    if (mdcRise)
    begin
      case (q.state)
        ST_IDLE:
        begin
          if (mdioS)
          begin
            if (q.ones != PREAMBLE_LEN)
              next_q.ones = q.ones + 6'h01;
          end
          else if (q.ones == PREAMBLE_LEN)
          begin
            next_q.ones = 6'h00;
            next_q.state = ST_START;
          end
          else
            next_q.ones = 6'h00;
        end
        ST_START:
        begin
          next_q.cnt = 5'h00;
          next_q.state = mdioS ? ST_OPCODE : ST_IDLE;
        end
        ST_OPCODE:
        begin
          next_q.shift = {q.shift[14:0], mdioS};
          if (q.cnt == `PBC_OP_LAST)
          begin
            next_q.cnt = 5'h00;
            next_q.isRead = (opcNow == `PBC_OP_READ);
            if (opcNow == `PBC_OP_READ || opcNow == `PBC_OP_WRITE)
              next_q.state = ST_ADDR;
            else
              next_q.state = ST_IDLE;
          end
          else
            next_q.cnt = q.cnt + 5'h01;
        end
        ST_ADDR:
        begin
          next_q.shift = {q.shift[14:0], mdioS};
          if (q.cnt == `PBC_ADDR_LAST)
          begin
            next_q.cnt = 5'h00;
            next_q.regZero = regZeroNow;
            if (addrNow[9:5] == PHY_ADDR)
            begin
              next_q.shift = regZeroNow ? readValue : 16'h0000;
              next_q.state = ST_TURN;
            end
            else
              next_q.state = ST_IDLE;
          end
          else
            next_q.cnt = q.cnt + 5'h01;
        end
        ST_TURN:
        begin
          if (q.cnt == `PBC_TA_LAST)
          begin
            next_q.cnt = 5'h00;
            if (q.isRead)
            begin
              next_q.mdioOut = q.shift[15];
              next_q.shift = {q.shift[14:0], 1'h0};
              next_q.state = ST_RDATA;
            end
            else
              next_q.state = ST_WDATA;
          end
          else
          begin
            next_q.cnt = q.cnt + 5'h01;
            if (q.isRead)
            begin
              next_q.mdioOe_n = 1'h0;
              next_q.mdioOut = 1'h0;
            end
          end
        end
        ST_WDATA:
        begin
          next_q.shift = wrValue;
          if (q.cnt == `PBC_DATA_LAST)
            next_q.state = ST_IDLE;
          else
            next_q.cnt = q.cnt + 5'h01;
        end
        ST_RDATA:
        begin
          if (q.cnt == `PBC_DATA_LAST)
          begin
            next_q.mdioOe_n = 1'h1;
            next_q.mdioOut = 1'h0;
            next_q.state = ST_IDLE;
          end
          else
          begin
            next_q.mdioOut = q.shift[15];
            next_q.shift = {q.shift[14:0], 1'h0};
            next_q.cnt = q.cnt + 5'h01;
          end
        end
        default:
        begin
          next_q.mdioOe_n = 1'h1;
          next_q.mdioOut = 1'h0;
          next_q.state = ST_IDLE;
        end
      endcase
    end

    // Register writes; reserved bits are dropped
    if (wrCommit && strapS && !fiberS)
      next_q.anEnableBit = wrValue[`PBC_BIT_AN_EN];
    if (wrCommit && !fiberS)
      next_q.speedBit = wrValue[`PBC_BIT_SPEED];
    if (wrCommit)
      next_q.powerDown = wrValue[`PBC_BIT_PDOWN];
    if (wrCommit && !q.anEnable)
      next_q.duplexBit = wrValue[`PBC_BIT_DUPLEX];
    if (q.anEnable && anDone)
      next_q.duplexBit = anFullDuplex;
    // Pin change wins over a write in the same cycle
    next_q.fxDupPrev = fxDupS;
    if (fiberS && (fxDupS != q.fxDupPrev))
      next_q.duplexBit = fxDupS;
    next_q.anRestart = wrCommit && wrValue[`PBC_BIT_RESTART] &&
                       q.anEnable;

    next_q.anEnable = strapS && !fiberS && q.anEnableBit;
    // Negotiated results replace the forced bits
    if (fiberS)
      next_q.linkSpeed100 = 1'h1;
    else if (q.anEnable)
      next_q.linkSpeed100 = anSpeed100;
    else
      next_q.linkSpeed100 = q.speedBit;
    next_q.linkFullDuplex = q.anEnable ? anFullDuplex : q.duplexBit;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= RESET_STATE;
    else
      q <= next_q;
  end

  assign mdioOut = q.mdioOut;
  assign mdioOe_n = q.mdioOe_n;
  assign anEnable = q.anEnable;
  assign anRestart = q.anRestart;
  assign powerDown = q.powerDown;
  assign linkSpeed100 = q.linkSpeed100;
  assign linkFullDuplex = q.linkFullDuplex;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_strap_forces_off: assert property (
    !strapS |=> !anEnable)
    else $error("negotiation enabled with strap low");
  a_write_reenables: assert property (
    wrCommit && wrValue[`PBC_BIT_AN_EN] && strapS && !fiberS
    |=> q.anEnableBit ##1 (anEnable || !$past(strapS) || $past(fiberS)))
    else $error("write of one did not re-enable negotiation");
  a_strap_blocks_write: assert property (
    wrCommit && !strapS |=> $stable(q.anEnableBit))
    else $error("enable bit changed while strap low");
  a_fiber_locks_enable: assert property (
    fiberS && wrCommit |=> $stable(q.anEnableBit) && !anEnable)
    else $error("enable bit writable in fiber mode");
  a_power_follows: assert property (
    wrCommit |=> powerDown == $past(wrValue[`PBC_BIT_PDOWN]))
    else $error("power-down did not follow write");
  a_restart_pulse: assert property (
    wrCommit && wrValue[`PBC_BIT_RESTART] && anEnable
    |=> anRestart ##1 !anRestart)
    else $error("restart not a single pulse");
  a_restart_gated: assert property (
    anRestart |-> $past(anEnable) && $past(wrCommit))
    else $error("restart without negotiation enabled");
  a_duplex_forced: assert property (
    wrCommit && !anEnable && !fiberS
    |=> q.duplexBit == $past(wrValue[`PBC_BIT_DUPLEX]))
    else $error("forced duplex not taken");
  a_duplex_ro: assert property (
    wrCommit && anEnable && !anDone && !fiberS |=> $stable(q.duplexBit))
    else $error("duplex writable during negotiation");
  a_speed_forced: assert property (
    !anEnable && !fiberS |=> linkSpeed100 == $past(q.speedBit))
    else $error("forced speed not applied");
  a_read_release: assert property (
    mdcRise && q.state == ST_RDATA && q.cnt == `PBC_DATA_LAST
    |=> mdioOe_n && q.state == ST_IDLE)
    else $error("data line not released after read");
  c_read_frame: cover property (
    q.state == ST_RDATA ##[1:300] q.state == ST_IDLE);
  c_write_commit: cover property (wrCommit);
  c_restart: cover property (anRestart);
  c_powered_read: cover property (powerDown && q.state == ST_RDATA);

endmodule : pbc_regs

// ---- pbc_consts.svh ----
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

// Register index of the control register
`define PBC_REG_CONTROL 5'h00

// Field positions inside the control register
`define PBC_BIT_SPEED 13
`define PBC_BIT_AN_EN 12
`define PBC_BIT_PDOWN 11
`define PBC_BIT_RESTART 9
`define PBC_BIT_DUPLEX 8

// Reset values of the stored fields
`define PBC_RST_AN_EN 1'h1
`define PBC_RST_SPEED 1'h1
`define PBC_RST_PDOWN 1'h0
`define PBC_RST_DUPLEX 1'h0

// Management frame opcodes
`define PBC_OP_READ 2'h2
`define PBC_OP_WRITE 2'h1

// Management frame bit counts: preamble as a length, other fields as last index
`define PBC_PREAMBLE_LEN 6'h20
`define PBC_OP_LAST 5'h01
`define PBC_ADDR_LAST 5'h09
`define PBC_TA_LAST 5'h01
`define PBC_DATA_LAST 5'h0F

// Default management address of this device
`define PBC_PHY_ADDR 5'h01

`endif

// ---- pbc_pkg.sv ----
package pbc_pkg;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_START  = 7'h02,
    ST_OPCODE = 7'h04,
    ST_ADDR   = 7'h08,
    ST_TURN   = 7'h10,
    ST_WDATA  = 7'h20,
    ST_RDATA  = 7'h40
  } pbc_state_e;

  typedef struct packed {
    pbc_state_e state;
    logic [4:0] cnt;
    logic [5:0] ones;
    logic [15:0] shift;
    logic isRead;
    logic regZero;
    logic mdcPrev;
    logic mdioOut;
    logic mdioOe_n;
    logic anEnableBit;
    logic speedBit;
    logic powerDown;
    logic duplexBit;
    logic anRestart;
    logic anEnable;
    logic linkSpeed100;
    logic linkFullDuplex;
    logic fxDupPrev;
  } pbc_regs_s;

endpackage : pbc_pkg

// ---- pbc_sync.sv ----
`timescale 1ns/1ps

module pbc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] sync
);

  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pbc_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      sync <= '0;
    end
    else
    begin
      stage1 <= async;
      sync <= stage1;
    end
  end

endmodule : pbc_sync

// ---- pbc_mgr_model.sv ----
`timescale 1ns/1ps
`include "pbc_consts.svh"

module pbc_mgr_model (
  // Clock
  input wire logic clk,
  // Management wire
  output logic mdc,
  output logic mdioIn,
  input wire logic mdioOut,
  input wire logic mdioOe_n
);
  logic drv;
  logic bitOut;

  // Pull-up holds the wire high when nobody drives
  assign mdioIn = !mdioOe_n ? mdioOut : (drv ? bitOut : 1'b1);

  initial
  begin
    mdc = 1'b0;
    drv = 1'b0;
    bitOut = 1'b1;
  end

  // One management clock period, sample just before the rise
  task automatic cyc(input logic b, output logic s);
    bitOut = b;
    repeat (4) @(negedge clk);
    s = mdioIn;
    mdc = 1'b1;
    repeat (4) @(negedge clk);
    mdc = 1'b0;
  endtask : cyc

  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] rd);
    logic [31:0] hdr;
    logic s;
    hdr = {2'h1, op, pa, ra, 2'h2, wd};
    drv = 1'b1;
    repeat (32) cyc(1'b1, s);
    for (int i = 31; i >= 0; i--)
    begin
      // Release for turnaround on reads
      if (op == `PBC_OP_READ && i == 17)
        drv = 1'b0;
      cyc(hdr[i], s);
      if (i < 16)
        rd[i] = s;
    end
    drv = 1'b0;
  endtask : frame
endmodule : pbc_mgr_model

// ---- phy_basic_control_low_bits_bench.sv ----
`timescale 1ns/1ps
`include "pbc_consts.svh"

module phy_basic_control_low_bits_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mdc, mdioIn, mdioOut, mdioOe_n;
  logic strap = 1'b1;
  logic fiber = 1'b0;
  logic fdup = 1'b0;
  logic anDone = 1'b0;
  logic anFd = 1'b0;
  logic anSp = 1'b0;
  logic anEnable, anRestart, powerDown, linkSpeed100, linkFullDuplex;
  int nFail = 0;
  int cmpCount = 0;
  int nRestart = 0;
  logic [15:0] scratch;

  always #4 clk = ~clk;

  pbc_regs dut_u (
    .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdioIn(mdioIn),
    .mdioOut(mdioOut), .mdioOe_n(mdioOe_n),
    .negotiationStrapPin(strap), .fiberModePin(fiber),
    .fiberDuplexPin(fdup), .anDone(anDone), .anFullDuplex(anFd),
    .anSpeed100(anSp), .anEnable(anEnable), .anRestart(anRestart),
    .powerDown(powerDown), .linkSpeed100(linkSpeed100),
    .linkFullDuplex(linkFullDuplex)
  );

  pbc_mgr_model mgr_u (
    .clk(clk), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe_n(mdioOe_n)
  );

  always @(posedge clk)
    if (anRestart === 1'b1)
      nRestart++;

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmpCount++;
    if (g !== e)
    begin
      nFail++;
      $display("Error at %0t: word %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic chkb(input logic g, input logic e);
    cmpCount++;
    if (g !== e)
    begin
      nFail++;
      $display("Error at %0t: level %b expected %b", $time, g, e);
    end
  endtask : chkb

  task automatic wr(input logic [15:0] d);
    logic [15:0] x;
    mgr_u.frame(`PBC_OP_WRITE, `PBC_PHY_ADDR, `PBC_REG_CONTROL, d, x);
    repeat (4) @(negedge clk);
  endtask : wr

  task automatic rdchk(input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] x;
    mgr_u.frame(`PBC_OP_READ, `PBC_PHY_ADDR, ra, 16'h0000, x);
    chk(x, e);
  endtask : rdchk

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #300000;
    nFail++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    rdchk(`PBC_REG_CONTROL, 16'h3000);
    rdchk(5'h01, 16'h0000);
    chkb(anEnable, 1'b1);
    // Frame for another address must be ignored
    mgr_u.frame(`PBC_OP_WRITE, ~(`PBC_PHY_ADDR), `PBC_REG_CONTROL,
                16'h0800, scratch);
    rdchk(`PBC_REG_CONTROL, 16'h3000);
    $display("Test defaults done");
    // Forced speed and duplex, reserved bits written zero
    wr(16'h0000);
    chkb(linkSpeed100, 1'b0);
    wr(16'h2100);
    chkb(linkSpeed100, 1'b1);
    chkb(linkFullDuplex, 1'b1);
    wr(16'h2900);
    chkb(powerDown, 1'b1);
    rdchk(`PBC_REG_CONTROL, 16'h2900);
    wr(16'h0200);
    chk(16'(nRestart), 16'h0000);
    rdchk(`PBC_REG_CONTROL, 16'h0000);
    $display("Test forced done");
    // Negotiation back on with restart
    anDone = 1'b1;
    anFd = 1'b1;
    anSp = 1'b1;
    // Restart in the enabling write is disregarded: still disabled then
    wr(16'h1200);
    chk(16'(nRestart), 16'h0000);
    wr(16'h1200);
    chk(16'(nRestart), 16'h0001);
    chkb(anEnable, 1'b1);
    chkb(linkSpeed100, 1'b1);
    // Result no longer refreshed, so a taken write would show
    anDone = 1'b0;
    wr(16'h1000);
    rdchk(`PBC_REG_CONTROL, 16'h1100);
    chkb(linkFullDuplex, 1'b1);
    $display("Test negotiation done");
    // Strap low
    strap = 1'b0;
    repeat (8) @(negedge clk);
    chkb(anEnable, 1'b0);
    wr(16'h0000);
    rdchk(`PBC_REG_CONTROL, 16'h1000);
    strap = 1'b1;
    repeat (8) @(negedge clk);
    chkb(anEnable, 1'b1);
    $display("Test strap done");
    // Fiber mode
    fiber = 1'b1;
    repeat (8) @(negedge clk);
    rdchk(`PBC_REG_CONTROL, 16'h2000);
    fdup = 1'b1;
    repeat (8) @(negedge clk);
    chkb(linkFullDuplex, 1'b1);
    wr(16'h1000);
    rdchk(`PBC_REG_CONTROL, 16'h2000);
    chkb(anEnable, 1'b0);
    $display("Test fiber done");
    // Chip reset restores defaults
    fiber = 1'b0;
    fdup = 1'b0;
    repeat (8) @(negedge clk);
    wr(16'h0800);
    chkb(powerDown, 1'b1);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    rdchk(`PBC_REG_CONTROL, 16'h3000);
    chkb(anEnable, 1'b1);
    chkb(powerDown, 1'b0);
    $display("Test reset done");
    report_and_stop();
  end
endmodule : phy_basic_control_low_bits_bench
